// ---- hw/sfct_uart_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE_01] double speed divides baud ticks by 8 in async only
// [RULE_02] double speed receiver takes 8 samples per bit, not 16
// [RULE_03] slave clock is synchronised then edge detected; below fclk/4
// [RULE_04] polarity low: drive on rising, sample falling; high swaps
// [RULE_05] thirty formats: 5-9 data bits, parity none/even/odd, 1-2 stops
// [RULE_06] frame order: start, data lsb first, parity, stops
// [RULE_07] after a frame, start next at once or idle high
// [RULE_08] start bit low, stop bits and idle line high
// [RULE_09] one shared format for both directions; changes corrupt transfers
// [RULE_10] receiver ignores second stop; frame error if first stop low
// [RULE_11] parity is xor of data bits, inverted for odd
// [RULE_12] software changes rate or format only while link is quiet
// [RULE_13] tx complete when all sent; rx complete while data unread
// [RULE_14] software clears tx complete before each data write
// [RULE_15] shared address: select bit set writes control c, else baud high
// [RULE_16] transmit enable takes over the serial output pin
// [RULE_17] sync master mode (direction bit set) with transmitter on drives the transfer clock pin
// [RULE_18] data write fills buffer; moves to shifter when idle or done
// [RULE_19] unused upper data bits are dropped for short frames
// [RULE_20] baud down-counter reloads at zero or low write; ticks at zero
// [RULE_21] sync select picks sync mode; direction bit picks master/slave
// [RULE_22] software writes ninth bit before the low byte
// [RULE_23] buffer empty flag clears on data write until moved on
module sfct_uart_tx
  import sfct_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_wr_en,
  input  wire logic [2:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_rx_read,
  input  wire logic       i_xck_direction,
  input  wire logic       i_xck,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_txd_oe,
  output logic            o_xck,
  output logic            o_xck_oe,
  output logic            o_tx_buffer_empty,
  output logic            o_tx_complete,
  output logic            o_rx_complete,
  output logic            o_frame_error,
  output logic [8:0]      o_rx_data
);

  // configuration
  logic              u2x_r;
  logic              tx_enable_bit_r;
  logic              rxen_r;
  logic              tx_ninth_bit_r;
  logic              sync_mode_select_r;
  logic              clock_polarity_bit_r;
  sfct_fmt_t         fmt_r;
  logic [BHI_MSB:0]  bhi_r;
  logic [7:0]        blo_r;

  logic              wr_data;
  logic              wr_csa;
  logic              wr_csb;
  logic              wr_csc;
  logic              wr_bhi;
  logic              wr_blo;

  always_comb
  begin
    wr_data = i_wr_en && i_wr_addr == ADDR_DATA;
    wr_csa  = i_wr_en && i_wr_addr == ADDR_CSA;
    wr_csb  = i_wr_en && i_wr_addr == ADDR_CSB;
    wr_csc  = i_wr_en && i_wr_addr == ADDR_CSC_BHI
              && i_wr_data[CSC_SEL]; // [RULE_15]
    wr_bhi  = i_wr_en && i_wr_addr == ADDR_CSC_BHI
              && !i_wr_data[CSC_SEL]; // [RULE_15]
    wr_blo  = i_wr_en && i_wr_addr == ADDR_BAUD_LO;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      u2x_r   <= 1'b0;
      tx_enable_bit_r  <= 1'b0;
      rxen_r  <= 1'b0;
      tx_ninth_bit_r  <= 1'b0;
      sync_mode_select_r <= 1'b0;
      clock_polarity_bit_r <= 1'b0;
      fmt_r   <= '{size: SIZE_RST, parity: PAR_NONE, stop2: 1'b0};
      bhi_r   <= '0;
      blo_r   <= 8'h00;
    end
    else
    begin
      if (wr_csa)
        u2x_r <= i_wr_data[CSA_U2X];
      if (wr_csb)
      begin
        rxen_r        <= i_wr_data[CSB_RXEN];
        tx_enable_bit_r        <= i_wr_data[CSB_TX_ENABLE_BIT];
        fmt_r.size[2] <= i_wr_data[CSB_SIZE2];
        tx_ninth_bit_r        <= i_wr_data[CSB_TX_NINTH_BIT];
      end
      // format shared by both directions, applied at once
      if (wr_csc) // [RULE_09]
      begin
        sync_mode_select_r         <= i_wr_data[CSC_SYNC_MODE_SELECT];
        fmt_r.parity    <= i_wr_data[CSC_PAR_HI:CSC_PAR_LO];
        fmt_r.stop2     <= i_wr_data[CSC_STOP2];
        fmt_r.size[1:0] <= i_wr_data[CSC_SZ_HI:CSC_SZ_LO];
        clock_polarity_bit_r         <= i_wr_data[CSC_CLOCK_POLARITY_BIT];
      end
      if (wr_bhi)
        bhi_r <= i_wr_data[BHI_MSB:0];
      if (wr_blo)
        blo_r <= i_wr_data;
    end
  end

  // baud generator
  logic [BAUD_W-1:0] baud_cnt_r;
  logic              baud_tick;

  assign baud_tick = baud_cnt_r == '0; // [RULE_20]

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      baud_cnt_r <= '0;
    else if (wr_blo)
      baud_cnt_r <= {bhi_r, i_wr_data}; // [RULE_20]
    else if (baud_tick)
      baud_cnt_r <= {bhi_r, blo_r}; // [RULE_20]
    else
      baud_cnt_r <= baud_cnt_r - 1'b1;
  end

  // clock mode
  logic sync_mode;
  logic master;
  assign sync_mode = sync_mode_select_r; // [RULE_21]
  assign master    = sync_mode && i_xck_direction; // [RULE_21]

  // slave clock: first stage feeds only the second
  logic xs1_r;
  logic xs2_r;
  logic xs3_r;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end
    else
    begin
      xs1_r <= i_xck; // [RULE_03]
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  // master clock: baud tick toggles the pin, giving the divide by 2
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_xck    <= 1'b0;
      o_xck_oe <= 1'b0;
    end
    else
    begin
      o_xck_oe <= master && tx_enable_bit_r; // [RULE_17]
      if (!master)
        o_xck <= 1'b0;
      else if (baud_tick)
        o_xck <= !o_xck;
    end
  end

  logic xck_rise;
  logic xck_fall;
  logic drive_edge;
  logic sample_edge;
  always_comb
  begin
    if (master)
    begin
      xck_rise = baud_tick && !o_xck;
      xck_fall = baud_tick && o_xck;
    end
    else
    begin
      xck_rise = xs2_r && !xs3_r; // [RULE_03]
      xck_fall = !xs2_r && xs3_r; // [RULE_03]
    end
    drive_edge  = clock_polarity_bit_r ? xck_fall : xck_rise; // [RULE_04]
    sample_edge = clock_polarity_bit_r ? xck_rise : xck_fall; // [RULE_04]
  end

  // async bit prescaler
  logic [3:0] pre_r;
  logic [3:0] pre_last;
  logic       bit_tick;
  assign pre_last = u2x_r ? SPB_X2_LAST : SPB_LAST; // [RULE_01]

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pre_r <= 4'h0;
    else if (baud_tick)
      pre_r <= (pre_r >= pre_last) ? 4'h0 : pre_r + 4'h1;
  end

  // double speed has no effect once sync mode is chosen
  assign bit_tick = sync_mode ? drive_edge // [RULE_01]
                  : (baud_tick && pre_r == pre_last);

  // transmit buffer
  logic [7:0]  buf_r;
  logic        buf_empty_r;
  sfct_tx_st_t st_r;
  logic        load;
  logic        frame_end;

  assign load = bit_tick && tx_enable_bit_r && !buf_empty_r
                && (st_r == TX_IDLE || st_r == TX_DONE); // [RULE_18]
  assign frame_end = bit_tick && st_r == TX_DONE && buf_empty_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      buf_r <= 8'h00;
    else if (wr_data)
      buf_r <= i_wr_data; // [RULE_18]
  end

  // a write in the cycle of the move refills the buffer
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      buf_empty_r <= 1'b1;
    else if (wr_data)
      buf_empty_r <= 1'b0; // [RULE_23]
    else if (load)
      buf_empty_r <= 1'b1; // [RULE_23]
  end

  // completion flag: hardware set beats software clear
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_tx_complete <= 1'b0;
    else if (frame_end)
      o_tx_complete <= 1'b1; // [RULE_13]
    else if (wr_csa && i_wr_data[CSA_TXC])
      o_tx_complete <= 1'b0;
  end

  // shifter
  logic [8:0] shift_r;
  logic [3:0] bitc_r;
  logic       par_r;
  logic [8:0] masked;
  logic [3:0] nbits;

  assign nbits  = sfct_nbits(fmt_r.size); // [RULE_05]
  assign masked = {tx_ninth_bit_r, buf_r}
                  & ~(9'h1FF << nbits); // [RULE_19]

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r    <= TX_IDLE;
      shift_r <= 9'h000;
      bitc_r  <= 4'h0;
      par_r   <= 1'b0;
      o_txd   <= 1'b1;
    end
    else if (!tx_enable_bit_r)
    begin
      st_r  <= TX_IDLE;
      o_txd <= 1'b1; // [RULE_08]
    end
    else if (bit_tick)
    begin
      case (st_r)
        TX_IDLE, TX_DONE:
          if (load)
          begin
            o_txd   <= 1'b0; // [RULE_08]
            shift_r <= masked;
            bitc_r  <= 4'h0;
            par_r   <= ^masked
                       ^ (fmt_r.parity == PAR_ODD); // [RULE_11]
            st_r    <= TX_DATA; // [RULE_07]
          end
          else
          begin
            o_txd <= 1'b1; // [RULE_07]
            st_r  <= TX_IDLE;
          end
        TX_DATA:
        begin
          o_txd   <= shift_r[0]; // [RULE_06]
          shift_r <= shift_r >> 1;
          bitc_r  <= bitc_r + 4'h1;
          if (bitc_r == nbits - 4'h1)
            st_r <= (fmt_r.parity == PAR_NONE) ? TX_STOP1 : TX_PARITY;
        end
        TX_PARITY:
        begin
          o_txd <= par_r; // [RULE_11]
          st_r  <= TX_STOP1;
        end
        TX_STOP1:
        begin
          o_txd <= 1'b1; // [RULE_08]
          st_r  <= fmt_r.stop2 ? TX_STOP2 : TX_DONE;
        end
        TX_STOP2:
        begin
          o_txd <= 1'b1; // [RULE_08]
          st_r  <= TX_DONE;
        end
        default:
          st_r <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_txd_oe <= 1'b0;
    else
      o_txd_oe <= tx_enable_bit_r; // [RULE_16]
  end

  always_comb
  begin
    o_tx_buffer_empty = buf_empty_r;
  end

  // receive path shares the format and rate settings
  sfct_rx_unit u_rx (
    .i_sys_clk   (i_sys_clk),
    .i_rstn      (i_rstn),
    .i_tick      (baud_tick),
    .i_sample    (sample_edge), // [RULE_04]
    .i_sync      (sync_mode),
    .i_u2x       (u2x_r), // [RULE_02]
    .i_en        (rxen_r),
    .i_fmt       (fmt_r), // [RULE_09]
    .i_rxd       (i_rxd),
    .i_read      (i_rx_read),
    .o_data      (o_rx_data),
    .o_complete  (o_rx_complete),
    .o_frame_err (o_frame_error)
  );

endmodule
`default_nettype wire

// ---- hw/sfct_pkg.sv ----
package sfct_pkg;

  // write-port address map
  localparam logic [2:0] ADDR_DATA    = 3'h0;
  localparam logic [2:0] ADDR_CSA     = 3'h1;
  localparam logic [2:0] ADDR_CSB     = 3'h2;
  localparam logic [2:0] ADDR_CSC_BHI = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;

  // field positions
  localparam int CSA_TXC    = 6;
  localparam int CSA_U2X    = 1;
  localparam int CSB_RXEN   = 4;
  localparam int CSB_TX_ENABLE_BIT   = 3;
  localparam int CSB_SIZE2  = 2;
  localparam int CSB_TX_NINTH_BIT   = 0;
  localparam int CSC_SEL    = 7;
  localparam int CSC_SYNC_MODE_SELECT  = 6;
  localparam int CSC_PAR_HI = 5;
  localparam int CSC_PAR_LO = 4;
  localparam int CSC_STOP2  = 3;
  localparam int CSC_SZ_HI  = 2;
  localparam int CSC_SZ_LO  = 1;
  localparam int CSC_CLOCK_POLARITY_BIT  = 0;
  localparam int BHI_MSB    = 3;

  localparam int BAUD_W = 12;

  // last count of the bit prescaler / sampler
  localparam logic [3:0] SPB_LAST    = 4'hF;
  localparam logic [3:0] SPB_X2_LAST = 4'h7;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD  = 2'h3;
  localparam logic [2:0] SIZE_9   = 3'h7;
  localparam logic [2:0] SIZE_RST = 3'h3;

  typedef struct packed {
    logic [2:0] size;
    logic [1:0] parity;
    logic       stop2;
  } sfct_fmt_t;

  typedef enum logic [5:0] {
    TX_IDLE   = 6'h01,
    TX_DATA   = 6'h02,
    TX_PARITY = 6'h04,
    TX_STOP1  = 6'h08,
    TX_STOP2  = 6'h10,
    TX_DONE   = 6'h20
  } sfct_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } sfct_rx_st_t;

  function automatic logic [3:0] sfct_nbits(input logic [2:0] size);
    case (size)
      3'h0:    sfct_nbits = 4'h5;
      3'h1:    sfct_nbits = 4'h6;
      3'h2:    sfct_nbits = 4'h7;
      SIZE_9:  sfct_nbits = 4'h9;
      default: sfct_nbits = 4'h8;
    endcase
  endfunction

endpackage

// ---- hw/sfct_rx_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfct_rx_unit
  import sfct_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_tick,
  input  wire logic       i_sample,
  input  wire logic       i_sync,
  input  wire logic       i_u2x,
  input  wire logic       i_en,
  input  wire sfct_fmt_t  i_fmt,
  input  wire logic       i_rxd,
  input  wire logic       i_read,
  output logic [8:0]      o_data,
  output logic            o_complete,
  output logic            o_frame_err
);

  sfct_rx_st_t st_r;
  logic [3:0]  cnt_r;
  logic [3:0]  bitc_r;
  logic [8:0]  shift_r;
  logic [3:0]  spb_last;
  logic [3:0]  cmp;
  logic        strobe;
  logic        stop_hit;

  always_comb
  begin
    spb_last = (i_u2x && !i_sync) ? SPB_X2_LAST : SPB_LAST; // [RULE_02]
    cmp      = (st_r == RX_START) ? (spb_last >> 1) : spb_last;
    strobe   = i_sync ? i_sample : (i_tick && cnt_r == cmp);
    stop_hit = (st_r == RX_STOP) && strobe;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_r <= 4'h0;
    else if (st_r == RX_IDLE || strobe)
      cnt_r <= 4'h0;
    else if (i_tick)
      cnt_r <= cnt_r + 4'h1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r    <= RX_IDLE;
      bitc_r  <= 4'h0;
      shift_r <= 9'h000;
    end
    else
    begin
      case (st_r)
        RX_IDLE:
        begin
          bitc_r  <= 4'h0;
          shift_r <= 9'h000;
          if (i_en && !i_rxd && (!i_sync || i_sample))
            st_r <= i_sync ? RX_DATA : RX_START;
        end
        RX_START:
          if (strobe)
            st_r <= i_rxd ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (strobe)
          begin
            shift_r[bitc_r] <= i_rxd;
            bitc_r <= bitc_r + 4'h1;
            if (bitc_r == sfct_nbits(i_fmt.size) - 4'h1)
              st_r <= (i_fmt.parity == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        RX_PAR:
          if (strobe)
            st_r <= RX_STOP;
        RX_STOP:
          if (strobe)
            st_r <= RX_IDLE; // [RULE_10]
        default:
          st_r <= RX_IDLE;
      endcase
    end
  end

  // a new frame beats a read in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_data      <= 9'h000;
      o_complete  <= 1'b0;
      o_frame_err <= 1'b0;
    end
    else if (stop_hit)
    begin
      o_data      <= shift_r;
      o_complete  <= 1'b1; // [RULE_13]
      o_frame_err <= !i_rxd; // [RULE_10]
    end
    else if (i_read)
      o_complete <= 1'b0;
  end

endmodule
`default_nettype wire

// ---- dv/sfct_uart_tx_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfct_uart_tx_monitor
  import sfct_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_wr_en,
  input  wire logic [2:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_rx_read,
  input  wire logic       o_txd,
  input  wire logic       o_txd_oe,
  input  wire logic       o_xck_oe,
  input  wire logic       o_tx_buffer_empty,
  input  wire logic       o_tx_complete,
  input  wire logic       o_rx_complete,
  input  wire logic       o_frame_error,
  input  wire logic [8:0] o_rx_data
);
  logic clr_q_r;

  // registered clear request, so the flag drop can be tied to it
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      clr_q_r <= 1'b0;
    else
      clr_q_r <= i_wr_en && i_wr_addr == ADDR_CSA && i_wr_data[CSA_TXC];
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_data_wr;
    i_wr_en && i_wr_addr == ADDR_DATA;
  endsequence
  sequence s_moved;
    $rose(o_tx_buffer_empty);
  endsequence
  // shortest bit is two clocks (sync master, divisor 0)
  sequence s_start_bit;
    !o_txd ##1 !o_txd;
  endsequence

  line_idle_a: assert property (!o_txd_oe |-> o_txd)
    else $error("serial output low while transmitter off");
  buf_fill_a: assert property (s_data_wr |=> !o_tx_buffer_empty)
    else $error("buffer empty flag set after data write");
  move_start_a: assert property (s_moved |-> s_start_bit)
    else $error("no start bit when buffer moved to shifter");
  done_idle_a: assert property (
    $rose(o_tx_complete) |-> o_txd && (o_tx_buffer_empty
      || $past(i_wr_en && i_wr_addr == ADDR_DATA)))
    else $error("transmit complete while line or buffer busy");
  done_clear_a: assert property ($fell(o_tx_complete) |-> clr_q_r)
    else $error("transmit complete dropped without a clear write");
  rx_hold_a: assert property (
    $fell(o_rx_complete) |-> $past(i_rx_read))
    else $error("receive complete dropped without a read");
  rx_update_a: assert property (
    $changed(o_rx_data) || $changed(o_frame_error) |-> o_rx_complete)
    else $error("receive result changed without a new frame");
  xck_own_a: assert property (o_xck_oe |-> o_txd_oe)
    else $error("clock pin driven with transmitter off");
endmodule

bind sfct_uart_tx sfct_uart_tx_monitor i_mon
(
  .i_sys_clk,
  .i_rstn,
  .i_wr_en,
  .i_wr_addr,
  .i_wr_data,
  .i_rx_read,
  .o_txd,
  .o_txd_oe,
  .o_xck_oe,
  .o_tx_buffer_empty,
  .o_tx_complete,
  .o_rx_complete,
  .o_frame_error,
  .o_rx_data
);
`default_nettype wire

// ---- dv/sfct_serial_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfct_serial_peer
(
  input  wire logic i_sys_clk,
  input  wire logic i_line,
  output var  logic o_line,
  input  var  int   i_bit_clks,
  input  var  int   i_nbits,
  input  wire logic i_par_en,
  input  wire logic i_stop2
);
  int q_data[$];
  int q_par[$];
  int q_stop[$];

  initial o_line = 1'b1;

  // mid-bit sampling from the falling start edge
  always
  begin
    int d;
    int p;
    int s;
    @(negedge i_line);
    repeat (i_bit_clks / 2) @(posedge i_sys_clk);
    if (i_line === 1'b0)
    begin
      d = 0;
      p = 0;
      for (int k = 0; k < i_nbits; k++)
      begin
        repeat (i_bit_clks) @(posedge i_sys_clk);
        d[k] = i_line;
      end
      if (i_par_en)
      begin
        repeat (i_bit_clks) @(posedge i_sys_clk);
        p = i_line;
      end
      repeat (i_bit_clks) @(posedge i_sys_clk);
      s = i_line;
      if (i_stop2)
      begin
        repeat (i_bit_clks) @(posedge i_sys_clk);
        s = s & i_line;
      end
      q_data.push_back(d);
      q_par.push_back(p);
      q_stop.push_back(s);
    end
  end

  // stop levels given by the caller, a low one only on purpose
  task automatic send(input int d, input logic s1, input logic s2);
    o_line = 1'b0;
    repeat (i_bit_clks) @(negedge i_sys_clk);
    for (int k = 0; k < i_nbits; k++)
    begin
      o_line = d[k];
      repeat (i_bit_clks) @(negedge i_sys_clk);
    end
    o_line = s1;
    repeat (i_bit_clks) @(negedge i_sys_clk);
    o_line = s2;
    repeat (i_bit_clks) @(negedge i_sys_clk);
    o_line = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/sfct_uart_tx_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfct_uart_tx_tb_top
  import sfct_pkg::*;
;
  logic        i_sys_clk;
  logic        i_rstn;
  logic        i_wr_en;
  logic [2:0]  i_wr_addr;
  logic [7:0]  i_wr_data;
  logic        i_rx_read;
  logic        i_xck_direction;
  logic        i_xck;
  logic        i_rxd;
  logic        o_txd;
  logic        o_txd_oe;
  logic        o_xck;
  logic        o_xck_oe;
  logic        o_tx_buffer_empty;
  logic        o_tx_complete;
  logic        o_rx_complete;
  logic        o_frame_error;
  logic [8:0]  o_rx_data;
  int          mismatches;
  int          checked;
  int          bit_clks;
  int          nbits;
  int          d;
  int          p;
  int          n;
  logic        par_en;
  logic        stop2;
  logic        u2x;
  logic        prev;
  logic        xck_run;
  logic        xck_at;
  logic [2:0]  sz;
  logic [1:0]  par;
  logic [3:0]  rx_complete_flag;
  logic [31:0] seed;
  int          exp_q[$];
  logic [2:0]  sizes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0]  pars [3] = '{2'h0, 2'h2, 2'h3};
  logic [3:0]  rx_cases [3] = '{4'hC, 4'h5, 4'hA};

  sfct_uart_tx i_dut (.*);

  sfct_serial_peer i_peer
  (
    .i_sys_clk  (i_sys_clk),
    .i_line     (o_txd),
    .o_line     (i_rxd),
    .i_bit_clks (bit_clks),
    .i_nbits    (nbits),
    .i_par_en   (par_en),
    .i_stop2    (stop2)
  );

  always #2 i_sys_clk = ~i_sys_clk;
  always #12 if (xck_run) i_xck = ~i_xck;

  // clock level when the line falls, to see which edge drove it
  always @(negedge o_txd) xck_at = i_xck;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic pick(input int sel);
    pick = sel == 0 ? o_tx_buffer_empty : sel == 1 ? o_tx_complete :
           sel == 2 ? o_rx_complete : !o_txd;
  endfunction

  task automatic check(input logic [8:0] seen, input logic [8:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge i_sys_clk);
    i_wr_en = 1'b1;
    i_wr_addr = a;
    i_wr_data = v;
    @(negedge i_sys_clk);
    i_wr_en = 1'b0;
  endtask

  task automatic wait_on(input int sel);
    int k;
    for (k = 0; k < 5000 && pick(sel) !== 1'b1; k++)
      @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check(9'(pick(sel)), 9'h001, "wait bound ran out");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // about ten times the expected run length
  initial
  begin
    #400000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {i_sys_clk, i_rstn, i_wr_en, i_rx_read, i_xck_direction} = 5'h00;
    {i_xck, xck_run, i_wr_addr, i_wr_data} = 13'h0000;
    {mismatches, checked, bit_clks, nbits} = '0;
    {par_en, stop2} = 2'h0;
    seed = 32'h51406BBD;
    repeat (10) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    @(negedge i_sys_clk);
    check(9'({o_txd, o_txd_oe, o_xck, o_xck_oe, o_tx_buffer_empty,
              o_tx_complete, o_rx_complete, o_frame_error}), 9'h088,
          "reset outputs");
    check(o_rx_data, 9'h000, "reset data");
    $display("test reset done");
    for (int f = 0; f < 30; f++)
    begin
      sz = sizes[f / 6];
      par = pars[(f / 2) % 3];
      stop2 = f[0];
      u2x = f[2];
      nbits = (sz == SIZE_9) ? 9 : 32'(sz) + 5;
      par_en = par[1];
      bit_clks = u2x ? 8 : 16;
      // link quiet here, format changed between frames only
      wr(ADDR_CSA, {1'b0, 1'b1, 4'h0, u2x, 1'b0});
      wr(ADDR_CSC_BHI, {2'h2, par, stop2, sz[1:0], 1'b0});
      wr(ADDR_CSC_BHI, 8'h00);
      wr(ADDR_BAUD_LO, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
        seed = lfsr(seed);
        wait_on(0);
        wr(ADDR_CSB, {3'h0, 2'h3, sz[2], 1'b0, seed[8]});
        wr(ADDR_DATA, seed[7:0]);
        exp_q.push_back(32'(seed[8:0]) & ((1 << nbits) - 1));
      end
      wait_on(1);
      repeat (4) @(negedge i_sys_clk);
      check(9'(i_peer.q_data.size()), 9'h002, "frame count");
      while (exp_q.size() > 0 && i_peer.q_data.size() > 0)
      begin
        d = exp_q.pop_front();
        p = par_en ? ($countones(d) % 2) ^ 32'(par[0]) : 0;
        check(9'(i_peer.q_data.pop_front()), 9'(d), "data bits");
        check(9'(i_peer.q_par.pop_front()), 9'(p), "parity");
        check(9'(i_peer.q_stop.pop_front()), 9'h001, "stop");
      end
      exp_q.delete();
    end
    check(9'(o_tx_complete), 9'h001, "complete after frames");
    wr(ADDR_CSA, 8'h40);
    check(9'(o_tx_complete), 9'h000, "complete cleared");
    $display("test frame formats done");
    {nbits, bit_clks, par_en} = {32'd8, 32'd16, 1'b0};
    wr(ADDR_CSA, 8'h00);
    // clear the nine-bit size left by the last format
    wr(ADDR_CSB, 8'h18);
    for (int k = 0; k < 3; k++)
    begin
      rx_complete_flag = rx_cases[k];
      stop2 = rx_complete_flag[1];
      wr(ADDR_CSC_BHI, {4'h8, stop2, 3'h6});
      seed = lfsr(seed);
      i_peer.send(32'(seed[7:0]), rx_complete_flag[3], rx_complete_flag[2]);
      wait_on(2);
      check(o_rx_data, {1'b0, seed[7:0]}, "received data");
      check(9'(o_frame_error), 9'(rx_complete_flag[0]), "frame error");
      i_rx_read = 1'b1;
      @(negedge i_sys_clk);
      i_rx_read = 1'b0;
      check(9'(o_rx_complete), 9'h000, "read clears");
    end
    $display("test receive done");
    repeat (300) @(negedge i_sys_clk);
    wr(ADDR_CSC_BHI, 8'h86);
    wr(ADDR_DATA, 8'h00);
    wait_on(3);
    wr(ADDR_CSB, 8'h00);
    // enable is seen one edge after the write, the pins one edge later
    @(negedge i_sys_clk);
    check({7'h00, o_txd, o_txd_oe}, 9'h002, "abort idles line");
    $display("test abort done");
    wr(ADDR_CSB, 8'h08);
    i_xck_direction = 1'b1;
    wr(ADDR_CSC_BHI, 8'hC6);
    wr(ADDR_CSA, 8'h02);
    wr(ADDR_BAUD_LO, 8'h01);
    check(9'(o_xck_oe), 9'h001, "master drives clock");
    n = 0;
    prev = o_xck;
    repeat (20)
    begin
      @(negedge i_sys_clk);
      n += (o_xck !== prev) ? 1 : 0;
      prev = o_xck;
    end
    check(9'(n), 9'h00A, "master clock rate");
    i_xck_direction = 1'b0;
    xck_run = 1'b1;
    wr(ADDR_DATA, 8'h55);
    check(9'(o_xck_oe), 9'h000, "slave releases clock");
    wait_on(3);
    check(9'(o_txd), 9'h000, "slave start bit");
    check(9'(xck_at), 9'h001, "drive on rising clock");
    wait_on(1);
    wr(ADDR_CSC_BHI, 8'hC7);
    wr(ADDR_CSA, 8'h40);
    wr(ADDR_DATA, 8'hAA);
    wait_on(3);
    check(9'(xck_at), 9'h000, "drive on falling clock");
    $display("test sync clock done");
    print_verdict();
  end
endmodule
`default_nettype wire
